// *** inc/fwsr_map.svh ***
`ifndef FWSR_MAP_SVH
`define FWSR_MAP_SVH
`define FWSR_ADDR_W 19
`define FWSR_REG_CTRL 32'h0000_0000
`define FWSR_REG_ADDR 32'h0000_0004
`define FWSR_REG_EXP 32'h0000_0008
`define FWSR_REG_STAT 32'h0000_000c
`define FWSR_REG_LAST 32'h0000_0010
`define FWSR_CTRL_GO 0
`define FWSR_CTRL_TOGGLE 1
`define FWSR_BIT_POLL 7
`define FWSR_BIT_TOGGLE 6
`define FWSR_BIT_LIMIT 5
`define FWSR_RES_DONE 2'h1
`define FWSR_RES_FAIL 2'h2
`define FWSR_RESET_CMD 8'hf0
`define FWSR_RD_CYCLES 4'h4
`define FWSR_WR_CYCLES 4'h4
`endif

// *** inc/fwsr_pkg.sv ***
package fwsr_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_SETUP, ST_RD_LOW, ST_RD_DONE, ST_EVAL,
    ST_WR_SETUP, ST_WR_LOW, ST_WR_DONE
  } fwsr_state_t;
  typedef struct packed {
    fwsr_state_t st;
    logic [3:0] cnt;
    logic [1:0] nread;
    logic recheck;
    logic mode_toggle;
    logic [7:0] prev;
    logic [7:0] last;
    logic [7:0] expect_data;
    logic [18:0] poll_addr;
    logic [1:0] result;
    logic busy;
    logic [18:0] fa;
    logic [7:0] fdo;
    logic fdoe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic hready;
    logic [31:0] hrdata;
    logic ph_valid;
    logic ph_write;
    logic [31:0] ph_addr;
  } fwsr_state_s_t;
endpackage : fwsr_pkg

// *** logic/fwsr_host.sv ***
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "fwsr_map.svh"
module fwsr_host #(
  parameter int ADDR_W = 19
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  // Flash address width is fixed by the poll address register
  if (ADDR_W != `FWSR_ADDR_W) begin : g_addr_w_check
    $error("fwsr_host: unsupported ADDR_W");
  end

  fwsr_pkg::fwsr_state_s_t s_reg, s_next;

  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
    toggled = a[`FWSR_BIT_TOGGLE] ^ b[`FWSR_BIT_TOGGLE];
  endfunction : toggled

  always_comb begin
    s_next = s_reg;
    s_next.hready = 1'b1;
    // Bus data phase
    if (s_reg.ph_valid && s_reg.ph_write) begin
      case (s_reg.ph_addr)
        `FWSR_REG_CTRL: begin
          if (hwdata[`FWSR_CTRL_GO] && !s_reg.busy) begin
            s_next.busy = 1'b1;
            s_next.result = 2'h0;
            s_next.mode_toggle = hwdata[`FWSR_CTRL_TOGGLE];
            s_next.nread = 2'h0;
            s_next.recheck = 1'b0;
            s_next.st = fwsr_pkg::ST_RD_SETUP;
            s_next.cnt = 4'h0;
          end
        end
        `FWSR_REG_ADDR: s_next.poll_addr = hwdata[18:0];
        `FWSR_REG_EXP: s_next.expect_data = hwdata[7:0];
        default: ;
      endcase
    end
    s_next.ph_valid = hsel && hready && htrans[1];
    s_next.ph_write = hwrite;
    s_next.ph_addr = {haddr[31:2], 2'b00};
    // Flash sequencer; each read ends with a rising strobe
    case (s_reg.st)
      fwsr_pkg::ST_IDLE: begin
        s_next.ce_n = 1'b1;
        s_next.oe_n = 1'b1;
        s_next.we_n = 1'b1;
        s_next.fdoe = 1'b0;
      end
      fwsr_pkg::ST_RD_SETUP: begin
        s_next.fa = s_reg.poll_addr;
        s_next.fdoe = 1'b0;
        s_next.ce_n = 1'b0;
        s_next.oe_n = 1'b0;
        s_next.cnt = 4'h0;
        s_next.st = fwsr_pkg::ST_RD_LOW;
      end
      fwsr_pkg::ST_RD_LOW: begin
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == `FWSR_RD_CYCLES) begin
          s_next.prev = s_reg.last;
          s_next.last = flash_dq_in;
          s_next.ce_n = 1'b1;
          s_next.oe_n = 1'b1;
          s_next.st = fwsr_pkg::ST_RD_DONE;
        end
      end
      fwsr_pkg::ST_RD_DONE: begin
        s_next.nread = (s_reg.nread == 2'h3) ? s_reg.nread : s_reg.nread + 2'h1;
        s_next.st = fwsr_pkg::ST_EVAL;
      end
      fwsr_pkg::ST_EVAL: begin
        s_next.st = fwsr_pkg::ST_RD_SETUP;
        if (!s_reg.mode_toggle) begin
          // Polling: bit 7 matching expected on the second or a later read means done
          if (s_reg.last[`FWSR_BIT_POLL] == s_reg.expect_data[`FWSR_BIT_POLL]) begin
            if (s_reg.recheck || s_reg.nread >= 2'h2) begin
              s_next.result = `FWSR_RES_DONE;
              s_next.st = fwsr_pkg::ST_IDLE;
              s_next.busy = 1'b0;
            end else begin
              s_next.recheck = 1'b1;
            end
          end else if (s_reg.recheck) begin
            s_next.result = `FWSR_RES_FAIL;
            s_next.st = fwsr_pkg::ST_WR_SETUP;
          end else if (s_reg.last[`FWSR_BIT_LIMIT]) begin
            s_next.recheck = 1'b1;
          end
        end else if (s_reg.nread >= 2'h2) begin
          // Toggle: compare two successive reads
          if (!toggled(s_reg.prev, s_reg.last)) begin
            s_next.result = `FWSR_RES_DONE;
            s_next.st = fwsr_pkg::ST_IDLE;
            s_next.busy = 1'b0;
          end else if (s_reg.recheck) begin
            s_next.result = `FWSR_RES_FAIL;
            s_next.st = fwsr_pkg::ST_WR_SETUP;
          end else if (s_reg.last[`FWSR_BIT_LIMIT]) begin
            s_next.recheck = 1'b1;
          end
        end
      end
      fwsr_pkg::ST_WR_SETUP: begin
        s_next.fa = s_reg.poll_addr;
        s_next.fdo = `FWSR_RESET_CMD;
        s_next.fdoe = 1'b1;
        s_next.ce_n = 1'b0;
        s_next.we_n = 1'b0;
        s_next.cnt = 4'h0;
        s_next.st = fwsr_pkg::ST_WR_LOW;
      end
      fwsr_pkg::ST_WR_LOW: begin
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == `FWSR_WR_CYCLES) begin
          s_next.we_n = 1'b1;
          s_next.ce_n = 1'b1;
          s_next.st = fwsr_pkg::ST_WR_DONE;
        end
      end
      fwsr_pkg::ST_WR_DONE: begin
        s_next.fdoe = 1'b0;
        s_next.busy = 1'b0;
        s_next.st = fwsr_pkg::ST_IDLE;
      end
      default: s_next.st = fwsr_pkg::ST_IDLE;
    endcase
    // Read data loaded at the address phase so it stands in the data phase
    if (s_next.ph_valid && !s_next.ph_write) begin
      case (s_next.ph_addr)
        `FWSR_REG_CTRL: s_next.hrdata = {30'h0, s_next.mode_toggle, 1'b0};
        `FWSR_REG_ADDR: s_next.hrdata = {13'h0, s_next.poll_addr};
        `FWSR_REG_EXP: s_next.hrdata = {24'h0, s_next.expect_data};
        `FWSR_REG_STAT: s_next.hrdata = {29'h0, s_next.result, s_next.busy};
        `FWSR_REG_LAST: s_next.hrdata = {24'h0, s_next.last};
        default: s_next.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= fwsr_pkg::ST_IDLE;
      s_reg.ce_n <= 1'b1;
      s_reg.oe_n <= 1'b1;
      s_reg.we_n <= 1'b1;
      s_reg.hready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.hready;
  assign hrdata = s_reg.hrdata;
  assign hresp = 1'b0;
  assign flash_addr = s_reg.fa;
  assign flash_dq_out = s_reg.fdo;
  assign flash_dq_oe = s_reg.fdoe;
  assign flash_ce_n = s_reg.ce_n;
  assign flash_oe_n = s_reg.oe_n;
  assign flash_we_n = s_reg.we_n;
endmodule : fwsr_host

// *** sim/fwsr_flash_model.sv ***
`timescale 1ns/1ps
module fwsr_flash_model (
  // Flash pins
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  output logic [7:0] flash_dq_in
);
  int busy_left = 0;
  int resets = 0;
  logic erase = 1'b0;
  logic fail = 1'b0;
  logic tog = 1'b0;
  logic [7:0] data = 8'h00;
  logic [7:0] v;
  wire rd = !flash_ce_n && !flash_oe_n;
  wire wr = !flash_ce_n && !flash_we_n;
  always_comb begin
    if (busy_left > 0 || fail) begin
      v = {erase ? 1'b0 : ~data[7], tog, fail, data[4],
        erase | data[3], erase ? tog : data[2], data[1:0]};
    end else begin
      v = data;
    end
  end
  // Released bus shows the inverse
  assign flash_dq_in = rd ? v : ~v;
  always @(negedge rd) begin
    if (busy_left > 0 || fail) tog <= ~tog;
    if (busy_left > 0) busy_left <= busy_left - 1;
  end
  // Command data latched as the write strobe ends
  always @(negedge wr) begin
    if (flash_dq_oe && flash_dq_out == 8'hf0) begin
      resets <= resets + 1;
      fail <= 1'b0;
      busy_left <= 0;
    end
  end
endmodule : fwsr_flash_model

// *** sim/fwsr_host_sva.sv ***
`timescale 1ns/1ps
module fwsr_host_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Flash pins
  input wire logic [18:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_rd_wr_excl: assert property (flash_oe_n || flash_we_n)
    else $error("strobes overlap");
  a_reset_cmd: assert property (!flash_we_n |-> flash_dq_oe && flash_dq_out == 8'hf0)
    else $error("bad reset cmd");
  a_wr_len: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n)
    else $error("write length");
  a_rd_len: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*5] ##1 flash_oe_n)
    else $error("read length");
  a_rd_gap: assert property ($rose(flash_oe_n) |=> flash_oe_n)
    else $error("no gap");
  a_ce_rd: assert property (!flash_oe_n |-> !flash_ce_n)
    else $error("read without ce");
  a_bus_free: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("contention");
  a_addr_hold: assert property (!flash_ce_n ##1 !flash_ce_n |-> $stable(flash_addr))
    else $error("addr moved");
endmodule : fwsr_host_sva

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] dt [4] = '{8'ha5, 8'hff, 8'hff, 8'h5a};
  wire logic hreadyout, hresp, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  wire logic [31:0] hrdata;
  wire logic [18:0] flash_addr;
  wire logic [7:0] flash_dq_in, flash_dq_out;
  int n_mismatch = 0;
  int tests_run = 0;
  fwsr_host uut (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .flash_addr, .flash_dq_in,
    .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n);
  fwsr_flash_model m (.flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n,
    .flash_we_n, .flash_dq_in);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask : xfer
  task run(input logic [31:0] c, input logic [31:0] e);
    int i;
    xfer(1'b1, 32'h0000_0000, c);
    i = 0;
    do begin xfer(1'b0, 32'h0000_000c, 32'h0000_0000); i++; end
    while (r[0] !== 1'b0 && i < 300);
    chk("status", e, r);
  endtask : run
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = '0; hwrite = 1'b0;
    htrans = 2'h0; hsize = 3'h2; hwdata = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    xfer(1'b0, 32'h0000_000c, 32'h0000_0000); chk("stat_rst", 32'h0000_0000, r);
    xfer(1'b0, 32'h0000_0020, 32'h0000_0000); chk("unmapped", 32'h0000_0000, r);
    for (int k = 0; k < 4; k++) begin
      m.busy_left = 3; m.data = dt[k]; m.erase = k[0] ^ k[1]; m.fail = k[1];
      xfer(1'b1, 32'h0000_0004, 32'h0000_1234);
      xfer(1'b1, 32'h0000_0008, {24'h0, dt[k]});
      run((k[0] ^ k[1]) ? 32'h0000_0003 : 32'h0000_0001, k[1] ? 32'h0000_0004 : 32'h0000_0002);
      chk("addr", 32'h0000_1234, {13'h0, flash_addr});
      chk("resets", k > 1 ? k - 1 : 0, m.resets);
      if (k < 2) begin
        xfer(1'b0, 32'h0000_0010, 32'h0000_0000); chk("last", {24'h0, dt[k]}, r);
      end
      $display("test %0d done", k);
    end
    close_out();
  end
endmodule : testbench
bind fwsr_host fwsr_host_sva chk_i (.ref_clk, .rst_n, .flash_addr, .flash_dq_out,
  .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n);
